// ---- verilog/rgb_step_pkg.sv ----
// rgb_step_pkg: register map, field layout, timing and decode tables
// for the blue step decoder.
// assumes a single 40 MHz clock domain and an 8-bit register port.
package rgb_step_pkg;

  // clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register byte addresses
  localparam logic [7:0] PATTERN_CTRL_ADDR = 8'h11;
  localparam logic [7:0] STEP_STATUS_ADDR = 8'h12;
  localparam logic [7:0] BLUE_LEVEL_ADDR = 8'h13;
  localparam logic [7:0] BLUE_TARGET_ADDR = 8'h14;
  localparam logic [7:0] STEP_BASE_ADDR = 8'h40;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h60;

  // pattern control fields
  localparam int CTRL_LOG_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'h03;
  localparam logic [7:0] SOFT_RESET_READ = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // step storage: two bytes per step, first byte even
  localparam int STEP_COUNT = 8;
  localparam int STEP_IDX_W = 3;
  localparam int STEP_BYTES = 16;
  localparam int STEP_AW = 4;

  // step byte layout
  localparam int DUR_HI_MSB = 1;
  localparam int DUR_HI_LSB = 0;
  localparam int DUR_LO_MSB = 7;
  localparam int DUR_LO_LSB = 6;
  localparam int BLUE_MSB = 5;
  localparam int BLUE_LSB = 3;
  localparam int RAMP_MSB = 2;
  localparam int RAMP_LSB = 0;

  localparam int LEVEL_W = 7;
  localparam int CNT_W = 32;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_FETCH_A,
    SEQ_FETCH_B,
    SEQ_LATCH,
    SEQ_RAMP,
    SEQ_HOLD
  } seq_state_type;

  typedef struct packed {
    logic [3:0] dur_code;
    logic [2:0] blue_code;
    logic [2:0] ramp_time_code;
  } step_fields_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // split fields of one step out of its two bytes
  function automatic step_fields_type decode_step(input logic [7:0] byte_a,
                                                  input logic [7:0] byte_b);
    step_fields_type f;
    f.dur_code = {byte_a[DUR_HI_MSB:DUR_HI_LSB],
                  byte_b[DUR_LO_MSB:DUR_LO_LSB]};
    f.blue_code = byte_b[BLUE_MSB:BLUE_LSB];
    f.ramp_time_code = byte_b[RAMP_MSB:RAMP_LSB];
    return f;
  endfunction

  // percent of full-scale current
  function automatic logic [6:0] blue_pct(input logic [2:0] code,
                                          input logic log_curve);
    logic [6:0] pct;
    pct = 7'h00;
    if (log_curve) begin
      case (code)
        3'h1: pct = 7'h01;
        3'h2: pct = 7'h02;
        3'h3: pct = 7'h04;
        3'h4: pct = 7'h0a;
        3'h5: pct = 7'h15;
        3'h6: pct = 7'h2e;
        3'h7: pct = 7'h64;
        default: pct = 7'h00;
      endcase
    end else begin
      case (code)
        3'h1: pct = 7'h07;
        3'h2: pct = 7'h0e;
        3'h3: pct = 7'h15;
        3'h4: pct = 7'h20;
        3'h5: pct = 7'h2e;
        3'h6: pct = 7'h47;
        3'h7: pct = 7'h64;
        default: pct = 7'h00;
      endcase
    end
    return pct;
  endfunction

  // colour transition time in ms
  function automatic int ramp_ms(input logic [2:0] code);
    int ms;
    case (code)
      3'h1: ms = 55;
      3'h2: ms = 110;
      3'h3: ms = 221;
      3'h4: ms = 442;
      3'h5: ms = 885;
      3'h6: ms = 1770;
      3'h7: ms = 3539;
      default: ms = 0;
    endcase
    return ms;
  endfunction

  // step length in ms
  function automatic int step_ms(input logic [3:0] code);
    int ms;
    case (code)
      4'h1: ms = 393;
      4'h2: ms = 590;
      4'h3: ms = 786;
      4'h4: ms = 983;
      4'h5: ms = 1180;
      4'h6: ms = 1376;
      4'h7: ms = 1573;
      4'h8: ms = 1769;
      4'h9: ms = 1966;
      4'ha: ms = 2163;
      4'hb: ms = 2359;
      4'hc: ms = 2556;
      4'hd: ms = 2753;
      4'he: ms = 2949;
      4'hf: ms = 3146;
      default: ms = 197;
    endcase
    return ms;
  endfunction

endpackage

// ---- verilog/step_memory.sv ----
// step_memory: small byte store with one write port and two read ports,
// each read port returning registered data one cycle after its address.
// assumes a synchronous clear pulse from the owner's soft reset.
`timescale 1ns/1ps
`default_nettype none
module step_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read ports
  input wire logic [AW-1:0] rd_a_addr_i,
  output logic [WIDTH-1:0] rd_a_data_o,
  input wire logic [AW-1:0] rd_b_addr_i,
  output logic [WIDTH-1:0] rd_b_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_a_data_o <= '0;
      rd_b_data_o <= '0;
    end else begin
      if (clr_i) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem[i] <= '0;
        end
      end else if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_a_data_o <= mem[rd_a_addr_i];
      rd_b_data_o <= mem[rd_b_addr_i];
    end
  end

endmodule
`default_nettype wire

// ---- verilog/rgb_pattern_step_decode.sv ----
// rgb_pattern_step_decode: register port, step store and blue step
// sequencer with intensity, transition and step length decode.
// assumes an 8-bit register master that never waits and one 40 MHz clock.
//
// Operation
// - step length code 0..15 gives 197 ms up to 3146 ms.
// - blue code from bits 5..3 of byte B, linear percent curve.
// - logarithmic mode maps blue codes to 0,1,2,4,10,21,46,100 percent.
// - one curve-select bit in pattern control picks linear or log.
// - bits 2..0 of byte B give transition time 0 up to 3539 ms.
// - any write to address 60h resets the whole device.
// - reading address 60h always returns zero.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rgb_pattern_step_decode #(
  parameter int CYCLES_PER_MS = rgb_step_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // pattern outputs
  output logic [6:0] blue_level_o,
  output logic [2:0] step_index_o,
  output logic ramp_active_o,
  output logic soft_reset_o
);

  function automatic logic in_step_range(input logic [7:0] addr);
    return addr[7:4] == rgb_step_pkg::STEP_BASE_ADDR[7:4];
  endfunction

  rgb_step_pkg::bus_req_type req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                 wr: reg_wr_i, rd: reg_rd_i};

  // register port state
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] rd_data, next_rd_data;
  logic rd_mem, next_rd_mem;
  logic soft_rst, next_soft_rst;

  // sequencer state
  rgb_step_pkg::seq_state_type state, next_state;
  logic [2:0] idx, next_idx;
  logic [7:0] byte_a, next_byte_a;
  logic [6:0] span, next_span;
  logic [6:0] level, next_level;
  logic [6:0] target, next_target;
  logic [31:0] step_cycles, next_step_cycles;
  logic [31:0] ramp_cycles, next_ramp_cycles;
  logic [31:0] cnt, next_cnt;
  logic [31:0] acc, next_acc;

  logic [7:0] mem_a_data;
  logic [7:0] mem_b_data;
  logic [3:0] mem_b_addr;
  logic mem_wr;
  logic run;
  logic log_curve;
  rgb_step_pkg::step_fields_type lat_fields;
  logic [6:0] lat_target;
  logic [6:0] diff;
  logic [31:0] acc_sum;
  logic step_end;

  assign run = ctrl[rgb_step_pkg::CTRL_RUN_BIT];
  assign log_curve = ctrl[rgb_step_pkg::CTRL_LOG_BIT];
  assign mem_wr = req.wr && in_step_range(req.addr) && !soft_rst;
  assign mem_b_addr = {idx, state == rgb_step_pkg::SEQ_FETCH_B};

  step_memory #(
    .WIDTH(rgb_step_pkg::DATA_W),
    .DEPTH(rgb_step_pkg::STEP_BYTES),
    .AW(rgb_step_pkg::STEP_AW)
  ) u_step_memory (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(soft_rst),
    .wr_en_i(mem_wr),
    .wr_addr_i(req.addr[3:0]),
    .wr_data_i(req.wdata),
    .rd_a_addr_i(req.addr[3:0]),
    .rd_a_data_o(mem_a_data),
    .rd_b_addr_i(mem_b_addr),
    .rd_b_data_o(mem_b_data)
  );

  // register port
  always_comb begin
    next_ctrl = ctrl;
    next_rd_data = rgb_step_pkg::UNMAPPED_READ;
    next_rd_mem = 1'b0;
    next_soft_rst = req.wr && req.addr == rgb_step_pkg::SOFT_RESET_ADDR;
    if (soft_rst) begin
      next_ctrl = rgb_step_pkg::CTRL_RESET;
    end else if (req.wr && req.addr == rgb_step_pkg::PATTERN_CTRL_ADDR) begin
      next_ctrl = req.wdata & rgb_step_pkg::CTRL_WR_MASK;
    end
    if (req.rd) begin
      if (in_step_range(req.addr)) begin
        next_rd_mem = 1'b1;
      end else if (req.addr == rgb_step_pkg::PATTERN_CTRL_ADDR) begin
        next_rd_data = ctrl;
      end else if (req.addr == rgb_step_pkg::STEP_STATUS_ADDR) begin
        next_rd_data = {3'h0, state == rgb_step_pkg::SEQ_RAMP,
                        state != rgb_step_pkg::SEQ_IDLE, idx};
      end else if (req.addr == rgb_step_pkg::BLUE_LEVEL_ADDR) begin
        next_rd_data = {1'b0, level};
      end else if (req.addr == rgb_step_pkg::BLUE_TARGET_ADDR) begin
        next_rd_data = {1'b0, target};
      end else if (req.addr == rgb_step_pkg::SOFT_RESET_ADDR) begin
        next_rd_data = rgb_step_pkg::SOFT_RESET_READ;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= rgb_step_pkg::CTRL_RESET;
      rd_data <= 8'h00;
      rd_mem <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      rd_data <= next_rd_data;
      rd_mem <= next_rd_mem;
      soft_rst <= next_soft_rst;
    end
  end

  assign reg_rdata_o = rd_mem ? mem_a_data : rd_data;

  // step decode and ramp arithmetic
  assign lat_fields = rgb_step_pkg::decode_step(byte_a, mem_b_data);
  assign lat_target = rgb_step_pkg::blue_pct(lat_fields.blue_code,
                                             log_curve);
  // span is fixed at latch so the ramp rate stays even to the end
  assign diff = (lat_target > level) ? 7'(lat_target - level)
                                     : 7'(level - lat_target);
  assign acc_sum = acc + {25'h0, span};
  assign step_end = (state == rgb_step_pkg::SEQ_RAMP ||
                     state == rgb_step_pkg::SEQ_HOLD) &&
                    cnt == step_cycles - 32'h1;

  // sequencer
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_byte_a = byte_a;
    next_span = span;
    next_level = level;
    next_target = target;
    next_step_cycles = step_cycles;
    next_ramp_cycles = ramp_cycles;
    next_cnt = cnt;
    next_acc = acc;
    if (soft_rst) begin
      next_state = rgb_step_pkg::SEQ_IDLE;
      next_idx = 3'h0;
      next_byte_a = 8'h00;
      next_span = 7'h00;
      next_level = 7'h00;
      next_target = 7'h00;
      next_step_cycles = 32'h0;
      next_ramp_cycles = 32'h0;
      next_cnt = 32'h0;
      next_acc = 32'h0;
    end else begin
      case (state)
        rgb_step_pkg::SEQ_IDLE: begin
          if (run) begin
            next_state = rgb_step_pkg::SEQ_FETCH_A;
          end
        end
        rgb_step_pkg::SEQ_FETCH_A: begin
          next_state = rgb_step_pkg::SEQ_FETCH_B;
        end
        rgb_step_pkg::SEQ_FETCH_B: begin
          next_byte_a = mem_b_data;
          next_state = rgb_step_pkg::SEQ_LATCH;
        end
        rgb_step_pkg::SEQ_LATCH: begin
          next_span = diff;
          next_target = lat_target;
          next_step_cycles = 32'(rgb_step_pkg::step_ms(lat_fields.dur_code)
                                 * CYCLES_PER_MS);
          next_ramp_cycles = 32'(rgb_step_pkg::ramp_ms(
                                 lat_fields.ramp_time_code)
                                 * CYCLES_PER_MS);
          next_cnt = 32'h0;
          next_acc = 32'h0;
          next_state = rgb_step_pkg::SEQ_RAMP;
        end
        rgb_step_pkg::SEQ_RAMP: begin
          next_cnt = cnt + 32'h1;
          if (ramp_cycles == 32'h0 || level == target) begin
            next_level = target;
            next_state = rgb_step_pkg::SEQ_HOLD;
          end else if (acc_sum >= ramp_cycles) begin
            // one percent per overflow spreads the change over the ramp
            next_acc = acc_sum - ramp_cycles;
            next_level = (target > level) ? 7'(level + 7'h01)
                                          : 7'(level - 7'h01);
          end else begin
            next_acc = acc_sum;
          end
        end
        rgb_step_pkg::SEQ_HOLD: begin
          next_cnt = cnt + 32'h1;
        end
        default: begin
          next_state = rgb_step_pkg::SEQ_IDLE;
        end
      endcase
      if (step_end) begin
        next_idx = 3'(idx + 3'h1);
        next_cnt = 32'h0;
        next_state = rgb_step_pkg::SEQ_FETCH_A;
      end
      if (!run) begin
        next_state = rgb_step_pkg::SEQ_IDLE;
        next_idx = 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rgb_step_pkg::SEQ_IDLE;
      idx <= 3'h0;
      byte_a <= 8'h00;
      span <= 7'h00;
      level <= 7'h00;
      target <= 7'h00;
      step_cycles <= 32'h0;
      ramp_cycles <= 32'h0;
      cnt <= 32'h0;
      acc <= 32'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      byte_a <= next_byte_a;
      span <= next_span;
      level <= next_level;
      target <= next_target;
      step_cycles <= next_step_cycles;
      ramp_cycles <= next_ramp_cycles;
      cnt <= next_cnt;
      acc <= next_acc;
    end
  end

  assign blue_level_o = level;
  assign step_index_o = idx;
  assign ramp_active_o = state == rgb_step_pkg::SEQ_RAMP;
  assign soft_reset_o = soft_rst;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic latch_now;
  assign latch_now = state == rgb_step_pkg::SEQ_LATCH && run && !soft_rst;

  sequence reset_write_s;
    reg_wr_i && reg_addr_i == rgb_step_pkg::SOFT_RESET_ADDR;
  endsequence

  sequence reset_done_s;
    soft_reset_o ##1 (state == rgb_step_pkg::SEQ_IDLE && level == 7'h00 &&
                      ctrl == rgb_step_pkg::CTRL_RESET);
  endsequence

  AST_STEP_LEN: assert property (
    latch_now |=> step_cycles ==
      32'(rgb_step_pkg::step_ms($past(lat_fields.dur_code)) * CYCLES_PER_MS))
    else $error("step length does not match its code");

  AST_BLUE_LINEAR: assert property (
    latch_now && !log_curve |=>
      target == rgb_step_pkg::blue_pct($past(mem_b_data[5:3]), 1'b0))
    else $error("linear blue level wrong");

  AST_BLUE_LOG: assert property (
    latch_now && log_curve && lat_fields.blue_code == 3'h4 |=>
      target == 7'h0a)
    else $error("log blue level wrong");

  AST_CURVE_SELECT: assert property (
    latch_now && lat_fields.blue_code == 3'h6 |=>
      target == ($past(log_curve) ? 7'h2e : 7'h47))
    else $error("curve select bit not honoured");

  AST_RAMP_TIME: assert property (
    latch_now |=> ramp_cycles ==
      32'(rgb_step_pkg::ramp_ms($past(mem_b_data[2:0])) * CYCLES_PER_MS))
    else $error("transition time does not match its code");

  AST_SOFT_RESET: assert property (
    reset_write_s |=> reset_done_s)
    else $error("soft reset write did not clear the device");

  AST_RESET_READ: assert property (
    reg_rd_i && reg_addr_i == rgb_step_pkg::SOFT_RESET_ADDR |=>
      reg_rdata_o == 8'h00)
    else $error("soft reset register read not zero");

  AST_RAMP_MOVE: assert property (
    state == rgb_step_pkg::SEQ_RAMP && run && !soft_rst && level != target
      && ramp_cycles != 32'h0 |=>
      (level == $past(level)) ||
      (level == 7'($past(level) + 7'h01) && $past(target) > $past(level)) ||
      (level == 7'($past(level) - 7'h01) && $past(target) < $past(level)))
    else $error("ramp moved the wrong way or too far");

  AST_HOLD_STEADY: assert property (
    state == rgb_step_pkg::SEQ_HOLD && !soft_rst |=> $stable(level))
    else $error("level changed during hold");

endmodule
`default_nettype wire

// ---- bench/rgb_pattern_step_decode_test.sv ----
// rgb_pattern_step_decode_test: self-checking bench for the blue step
// decoder, driving the register port directly.
// assumes one 40 MHz clock and a shortened millisecond count.
`timescale 1ns/1ps
`default_nettype none
module rgb_pattern_step_decode_test;
  localparam int CPM = 1;
  localparam int LIMIT = 60000;

  typedef struct {
    int len;
    int ramp;
    logic [7:0] pct;
    logic [2:0] nxt;
    bit chk;
  } step_exp_type;

  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [6:0] blue_level_o;
  logic [2:0] step_index_o;
  logic ramp_active_o;
  logic soft_reset_o;

  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int sr_cnt = 0;
  int since = 0;
  int rlen = 0;
  bit have_prev = 0;
  bit rd_seen = 0;
  bit ra_d = 0;
  logic [6:0] lvl_d = 7'h00;
  logic [7:0] rq[$];
  step_exp_type sq[$];
  int lin_t[8] = '{0, 7, 14, 21, 32, 46, 71, 100};
  int log_t[8] = '{0, 1, 2, 4, 10, 21, 46, 100};
  int ramp_t[8] = '{0, 55, 110, 221, 442, 885, 1770, 3539};
  int step_t[16] = '{197, 393, 590, 786, 983, 1180, 1376, 1573,
                     1769, 1966, 2163, 2359, 2556, 2753, 2949, 3146};

  rgb_pattern_step_decode #(.CYCLES_PER_MS(CPM)) dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .blue_level_o(blue_level_o),
    .step_index_o(step_index_o),
    .ramp_active_o(ramp_active_o),
    .soft_reset_o(soft_reset_o)
  );

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // the expected value is noted now and compared by the read monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic soft_rst(input int k);
    wr(rgb_step_pkg::SOFT_RESET_ADDR, 8'($urandom));
    repeat (3) @(posedge ref_clk_i);
    chkn("soft_reset_pulses", k, sr_cnt);
    rd(8'h41, 8'h00);
    rd(rgb_step_pkg::PATTERN_CTRL_ADDR, 8'h00);
    rd(rgb_step_pkg::BLUE_LEVEL_ADDR, 8'h00);
    rd(rgb_step_pkg::SOFT_RESET_ADDR, 8'h00);
  endtask

  // loads eight steps, runs one lap and notes each step's outcome
  task automatic run_round(input bit lg);
    logic [7:0] a;
    logic [7:0] b;
    logic [3:0] d;
    logic [2:0] bl;
    logic [2:0] rc;
    step_exp_type e;
    for (int n = 0; n < 8; n++) begin
      d = lg ? 4'(n + 8) : 4'(n);
      bl = 3'(n + 1);
      rc = lg ? 3'(n) : 3'h0;
      a = {6'($urandom), d[3:2]};
      b = {d[1:0], bl, rc};
      wr(rgb_step_pkg::STEP_BASE_ADDR + 8'(2 * n), a);
      wr(rgb_step_pkg::STEP_BASE_ADDR + 8'(2 * n + 1), b);
      e.pct = 8'(lg ? log_t[bl] : lin_t[bl]);
      e.len = step_t[d] * CPM + 3;
      e.ramp = ramp_t[rc] * CPM;
      e.chk = !(lg && n == 7);
      e.nxt = 3'(n + 1);
      sq.push_back(e);
    end
    rd(8'h4f, b);
    wr(rgb_step_pkg::PATTERN_CTRL_ADDR,
       8'((1 << rgb_step_pkg::CTRL_RUN_BIT) |
          (int'(lg) << rgb_step_pkg::CTRL_LOG_BIT)));
    while (sq.size() > 0) begin
      @(posedge ref_clk_i);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (rd_seen && rq.size() > 0) begin
      chk8("read_data", rq.pop_front(), reg_rdata_o);
    end
    rd_seen = reg_rd_i;
  end

  // step monitor: rise to rise of ramp_active_o spans one whole step
  always @(posedge ref_clk_i) begin
    step_exp_type e;
    if (soft_reset_o) begin
      have_prev = 0;
      sr_cnt++;
    end else if (ramp_active_o && !ra_d) begin
      if (have_prev && sq.size() > 0) begin
        e = sq.pop_front();
        chkn("step_len", e.len, since);
        chk8("step_index", {5'h0, e.nxt}, {5'h0, step_index_o});
        if (e.chk) begin
          chkn("ramp_len", e.ramp,
               (rlen >= e.ramp - 2 && rlen <= e.ramp + 2) ? e.ramp : rlen);
          chk8("blue_level", e.pct, {1'b0, lvl_d});
        end
      end
      have_prev = 1;
      since = 0;
      rlen = 0;
    end
    since++;
    if (ramp_active_o) begin
      rlen++;
    end
    ra_d = ramp_active_o;
    lvl_d = blue_level_o;
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h7fc0589b));
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(rgb_step_pkg::PATTERN_CTRL_ADDR, 8'h00);
    rd(rgb_step_pkg::SOFT_RESET_ADDR, 8'h00);
    wr(rgb_step_pkg::PATTERN_CTRL_ADDR, 8'hfc);
    rd(rgb_step_pkg::PATTERN_CTRL_ADDR, 8'h00);
    wr(8'h20, 8'($urandom));
    rd(8'h20, 8'h00);
    run_round(1'b0);
    soft_rst(1);
    run_round(1'b1);
    soft_rst(2);
    repeat (3) @(posedge ref_clk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
